// file: dv/i2c_slave_register_access_test.sv
// Purpose: self-checking bench for the two-wire register target
// Assumes: host model on the bus, register file and sink modelled here
// Notes:   writes land in a shadow copy committed on the apply pulse
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_register_access_test;
   import its_pkg::*;

   logic        clk;
   logic        rst_b;
   logic        m_scl;
   logic        m_sda;
   logic        scl_oe;
   logic        sda_oe;
   logic        scl_o;
   logic        sda_o;
   logic        nvm_v;
   logic [6:0]  nvm_a;
   logic [7:0]  rd_a;
   logic        wr_v;
   logic        wr_rdy;
   logic [7:0]  wr_a;
   logic [7:0]  wr_d;
   logic        ph;
   logic        apply;
   logic [6:0]  own;
   logic        saw_st;
   logic [7:0]  mem [256];
   logic [7:0]  shd [256];
   logic [15:0] expq [$];
   int          fails;
   int          num_checks;
   int          pops;
   int          cyc;
   wire logic       scl_w = m_scl & ~scl_oe;
   wire logic       sda_w = m_sda & ~sda_oe;
   wire logic [7:0] rd_d  = mem[rd_a];

   its_target DUT
   (
      .I_CLK_SYS     (clk),
      .I_RST_B       (rst_b),
      .I_SCL         (scl_w),
      .O_SCL_OUT     (scl_o),
      .O_SCL_OE      (scl_oe),
      .I_SDA         (sda_w),
      .O_SDA_OUT     (sda_o),
      .O_SDA_OE      (sda_oe),
      .I_NVM_VALID   (nvm_v),
      .I_NVM_ADDR    (nvm_a),
      .O_RD_ADDR     (rd_a),
      .I_RD_DATA     (rd_d),
      .O_WR_VALID    (wr_v),
      .I_WR_READY    (wr_rdy),
      .O_WR_ADDR     (wr_a),
      .O_WR_DATA     (wr_d),
      .I_PHASE_START (ph),
      .O_APPLY       (apply),
      .O_OWN_ADDR    (own)
   );

   its_host_bfm host (.o_scl(m_scl), .o_sda(m_sda), .i_scl(scl_w), .i_sda(sda_w));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // sink, commit and hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (scl_oe === 1'b1)
         saw_st <= 1'b1;
      if (apply === 1'b1)
         mem <= shd;
      if (wr_v === 1'b1 && wr_rdy === 1'b1)
      begin
         pops <= pops + 1;
         chk("write word", expq.pop_front(), {wr_a, wr_d});
         shd[wr_a] <= wr_d;
      end
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : do_reset

   task automatic wr_xfer(input logic [6:0] a, input logic [7:0] p, input logic [23:0] d,
                          input int n, input logic ak);
      logic k;
      host.start_cond();
      host.wr_byte({a, 1'b0}, k);
      chk("address ack", 16'(ak), 16'(k));
      host.wr_byte(p, k);
      chk("pointer ack", 16'(ak), 16'(k));
      for (int i = 0; i < n; i++)
      begin
         if (ak)
            expq.push_back({p + i[7:0], d[23-8*i -: 8]});
         host.wr_byte(d[23-8*i -: 8], k);
         chk("data ack", 16'(ak), 16'(k));
      end
      host.stop_cond();
   endtask : wr_xfer

   task automatic drain();
      for (int n = 0; n < 200 && expq.size() != 0; n++)
         @(posedge clk);
      chk("writes left", 16'h0000, 16'(expq.size()));
   endtask : drain

   task automatic phase(input logic e);
      @(posedge clk);
      ph <= 1'b1;
      #1 chk("apply pulse", 16'(e), 16'(apply));
      @(posedge clk);
      ph <= 1'b0;
      @(posedge clk);
   endtask : phase

   task automatic t_reset();
      do_reset();
      chk("own address", 16'(ITS_DEF_ADDR), 16'(own));
      chk("pointer", 16'(ITS_PTR_RST), 16'(rd_a));
      chk("idle data pin", 16'h0000, 16'(sda_oe));
      chk("data pin level", 16'h0000, 16'(sda_o));
      chk("clock pin level", 16'h0000, 16'(scl_o));
   endtask : t_reset

   task automatic t_write();
      wr_rdy <= 1'b0;
      saw_st <= 1'b0;
      fork
         wr_xfer(ITS_DEF_ADDR, 8'hfe, 24'ha55a3c, 3, 1'b1);
         begin
            repeat (1000) @(posedge clk);
            chk("stretch seen", 16'h0001, 16'(saw_st));
            chk("word waiting", 16'h0001, 16'(wr_v));
            wr_rdy <= 1'b1;
         end
      join
      drain();
   endtask : t_write

   task automatic t_apply();
      chk("not yet applied", 16'h00a2, 16'(mem[8'hfe]));
      phase(1'b1);
      chk("applied", 16'h003c, 16'(mem[8'h00]));
      phase(1'b0);
   endtask : t_apply

   task automatic t_read();
      logic       k;
      logic [7:0] d;
      host.start_cond();
      host.wr_byte({ITS_DEF_ADDR, 1'b0}, k);
      host.wr_byte(8'hfe, k);
      host.start_cond();
      host.wr_byte({ITS_DEF_ADDR, 1'b1}, k);
      chk("read address ack", 16'h0001, 16'(k));
      for (int i = 0; i < 3; i++)
      begin
         host.rd_byte(i < 2, d);
         chk("read byte", 16'(8'(24'ha55a3c >> (16 - 8*i))), 16'(d));
      end
      host.stop_cond();
   endtask : t_read

   task automatic t_other();
      int p0;
      p0 = pops;
      wr_xfer(7'h2c, 8'h10, 24'h770000, 1, 1'b0);
      repeat (20) @(posedge clk);
      chk("no write taken", 16'(p0), 16'(pops));
      nvm_v <= 1'b1;
      nvm_a <= 7'h31;
      do_reset();
      chk("override address", 16'h0031, 16'(own));
      wr_xfer(ITS_DEF_ADDR, 8'h10, 24'h990000, 1, 1'b0);
      wr_xfer(7'h31, 8'h10, 24'h990000, 1, 1'b1);
      drain();
   endtask : t_other

   initial
   begin
      rst_b = 1'b0;
      nvm_v = 1'b0;
      nvm_a = 7'h00;
      wr_rdy = 1'b1;
      ph = 1'b0;
      saw_st = 1'b0;
      fails = 0;
      num_checks = 0;
      pops = 0;
      cyc = 0;
      for (int i = 0; i < 256; i++)
      begin
         mem[i] = 8'(i) ^ 8'h5c;
         shd[i] = 8'(i) ^ 8'h5c;
      end
      t_reset();
      t_write();
      t_apply();
      t_read();
      t_other();
      wrap_up();
   end

endmodule : i2c_slave_register_access_test
`default_nettype wire

// file: dv/its_host_bfm.sv
// Purpose: two-wire bus host model that drives the target
// Assumes: open-drain lines with pull-ups, 125 ns bit period
// Notes:   honours clock stretching; a stuck clock is caught by the bench timeout
`timescale 1ns/1ps
`default_nettype none

module its_host_bfm
(
   output logic      o_scl,
   output logic      o_sda,
   input  wire logic i_scl,
   input  wire logic i_sda
);

   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic start_cond();
      o_sda = 1'b1;
      #40 o_scl = 1'b1;
      #62 o_sda = 1'b0;
      #62 o_scl = 1'b0;
      #23;
   endtask : start_cond

   task automatic stop_cond();
      o_sda = 1'b0;
      #40 o_scl = 1'b1;
      #62 o_sda = 1'b1;
      #62;
   endtask : stop_cond

   task automatic bit_cyc(input logic b, output logic s);
      o_sda = b;
      #40 o_scl = 1'b1;
      // target may hold the clock low
      wait (i_scl === 1'b1);
      #62 s = i_sda;
      o_scl = 1'b0;
      #23;
   endtask : bit_cyc

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_cyc(d[i], s);
      bit_cyc(1'b1, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_cyc(1'b1, d[i]);
      bit_cyc(~more, s);
   endtask : rd_byte

endmodule : its_host_bfm
`default_nettype wire

// file: include/its_pkg.sv
// Purpose: shared constants and types for the two-wire register target
// Assumes: system clock 125 MHz, bus pins sampled by that clock
// Notes:   bus address is 7 bits, register space is 8 bits wide

package its_pkg;

   localparam logic [6:0] ITS_DEF_ADDR     = 7'h2b;
   // location of the address override in nonvolatile memory
   localparam logic [7:0] ITS_NVM_ADDR_LOC = 8'h04;
   localparam logic [7:0] ITS_PTR_RST      = 8'h00;
   localparam logic [3:0] ITS_BIT_LAST     = 4'h8;
   localparam logic [3:0] ITS_BIT_ZERO     = 4'h0;
   localparam logic [7:0] ITS_PTR_STEP     = 8'h01;
   localparam int         ITS_BYTE_W       = 8;
   localparam int         ITS_WORD_W       = 16;
   localparam int         ITS_SYS_CLK_MHZ  = 125;
   localparam int         ITS_STD_KBPS     = 100;
   localparam int         ITS_FAST_KBPS    = 400;

   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'h0,
      ST_ADDR   = 4'h1,
      ST_A_ACK  = 4'h2,
      ST_PTR    = 4'h3,
      ST_P_ACK  = 4'h4,
      ST_WDATA  = 4'h5,
      ST_D_ACK  = 4'h6,
      ST_RDATA  = 4'h7,
      ST_MACK   = 4'h8,
      ST_MNEXT  = 4'h9,
      ST_IGNORE = 4'ha
   } its_state_e;

endpackage : its_pkg

// file: rtl/its_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   full and empty are exact; input ready drops only when both entries hold data

`timescale 1ns/1ps
`default_nettype none

module its_buf2
#(
   parameter int DW = 16
)
(
   input  wire logic          i_clk,
   input  wire logic          i_rst_b,
   input  wire logic          i_in_valid,
   output logic               o_in_ready,
   input  wire logic [DW-1:0] i_in_data,
   output logic               o_out_valid,
   input  wire logic          i_out_ready,
   output logic      [DW-1:0] o_out_data
);

   logic [DW-1:0] mem_r [2];
   logic          wr_r;
   logic          rd_r;
   logic [1:0]    cnt_r;
   wire           push = i_in_valid & o_in_ready;
   wire           pop  = o_out_valid & i_out_ready;

   assign o_in_ready  = (cnt_r != 2'h2);
   assign o_out_valid = (cnt_r != 2'h0);
   assign o_out_data  = mem_r[rd_r];

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         wr_r  <= 1'b0;
         rd_r  <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         wr_r  <= wr_r ^ push;
         rd_r  <= rd_r ^ pop;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : its_buf2

`default_nettype wire

// file: rtl/its_target.sv
// Purpose: two-wire bus target giving a host read and write access to the register space
// Assumes: bus pins are asynchronous and pass two flip-flops; phase start is a local pulse
// Notes:   writes leave through a two-entry buffer; a full buffer stretches the bus clock
//
// What this block does
// - acts only as bus target; handles standard and fast bus rates.
// - answers its 7-bit address: fixed default, or the nonvolatile override if programmed.
// - accepts access anytime; writes take effect at next processing phase start; words still in the buffer then wait for a phase start after a later write.
// - write: start, address with direction 0, acknowledge, then register pointer byte.
// - acknowledges every data byte after the pointer; host ends with stop.
// - each written data byte goes to the next register; pointer auto-increments.
// - read: host writes pointer, repeated start, address with direction 1.
// - device acknowledges, returns byte at pointer; host acks to continue, nacks to end.
// - pointer advances after each returned byte during sequential reads.
// - shadow contents lost at power-down; stored nonvolatile copy used at power-up.

`timescale 1ns/1ps
`default_nettype none

module its_target
   import its_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST_B,
   input  wire logic        I_SCL,
   output logic             O_SCL_OUT,
   output logic             O_SCL_OE,
   input  wire logic        I_SDA,
   output logic             O_SDA_OUT,
   output logic             O_SDA_OE,
   input  wire logic        I_NVM_VALID,
   input  wire logic [6:0]  I_NVM_ADDR,
   output logic      [7:0]  O_RD_ADDR,
   input  wire logic [7:0]  I_RD_DATA,
   output logic             O_WR_VALID,
   input  wire logic        I_WR_READY,
   output logic      [7:0]  O_WR_ADDR,
   output logic      [7:0]  O_WR_DATA,
   input  wire logic        I_PHASE_START,
   output logic             O_APPLY,
   output logic      [6:0]  O_OWN_ADDR
);
   import its_pkg::*;

   logic       scl_ff1_r;
   logic       scl_s_r;
   logic       scl_q_r;
   logic       sda_ff1_r;
   logic       sda_s_r;
   logic       sda_q_r;
   its_state_e st_r;
   its_state_e st_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic [7:0] ptr_r;
   logic [7:0] ptr_nxt;
   logic       sda_oe_r;
   logic       sda_oe_nxt;
   logic       stretch_r;
   logic       stretch_nxt;
   logic       rw_r;
   logic       rw_nxt;
   logic       push;
   logic       dirty_r;
   logic       loaded_r;
   logic [6:0] own_addr_r;
   logic       buf_in_ready;
   logic [15:0] buf_out_data;

   // edge and condition decode on synchronised pins
   wire scl_rise  = scl_s_r & ~scl_q_r;
   wire scl_fall  = ~scl_s_r & scl_q_r;
   wire bus_start = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
   wire bus_stop  = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
   wire bits_full = (cnt_r == ITS_BIT_LAST);
   wire byte_done = bits_full & scl_fall;
   wire addr_hit  = (sh_r[7:1] == own_addr_r);
   wire [7:0] ptr_inc = ptr_r + ITS_PTR_STEP;

   // two flip-flops before any logic, third stage for edges
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_B)
      begin
         scl_ff1_r <= 1'b1;
         scl_s_r   <= 1'b1;
         scl_q_r   <= 1'b1;
         sda_ff1_r <= 1'b1;
         sda_s_r   <= 1'b1;
         sda_q_r   <= 1'b1;
      end
      else
      begin
         scl_ff1_r <= I_SCL;
         scl_s_r   <= scl_ff1_r;
         scl_q_r   <= scl_s_r;
         sda_ff1_r <= I_SDA;
         sda_s_r   <= sda_ff1_r;
         sda_q_r   <= sda_s_r;
      end
   end

   // bus address caught once after reset release
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_B)
      begin
         loaded_r   <= 1'b0;
         own_addr_r <= ITS_DEF_ADDR;
      end
      else if (!loaded_r)
      begin
         loaded_r   <= 1'b1;
         own_addr_r <= I_NVM_VALID ? I_NVM_ADDR : ITS_DEF_ADDR;
      end
   end

   always_comb
   begin
      st_nxt      = st_r;
      cnt_nxt     = cnt_r;
      sh_nxt      = sh_r;
      tx_nxt      = tx_r;
      ptr_nxt     = ptr_r;
      sda_oe_nxt  = sda_oe_r;
      stretch_nxt = stretch_r;
      rw_nxt      = rw_r;
      push        = 1'b0;
      if (bus_start)
      begin
         st_nxt      = ST_ADDR;
         cnt_nxt     = ITS_BIT_ZERO;
         sda_oe_nxt  = 1'b0;
         stretch_nxt = 1'b0;
      end
      else if (bus_stop)
      begin
         st_nxt      = ST_IDLE;
         sda_oe_nxt  = 1'b0;
         stretch_nxt = 1'b0;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE, ST_IGNORE:
            begin
               sda_oe_nxt = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA:
            begin
               if (scl_rise && !bits_full)
               begin
                  sh_nxt  = {sh_r[6:0], sda_s_r};
                  cnt_nxt = cnt_r + 4'h1;
               end
               if (st_r == ST_ADDR && byte_done)
               begin
                  if (addr_hit)
                  begin
                     st_nxt     = ST_A_ACK;
                     sda_oe_nxt = 1'b1;
                     rw_nxt     = sh_r[0];
                  end
                  else
                  begin
                     st_nxt = ST_IGNORE;
                  end
               end
               if (st_r == ST_PTR && byte_done)
               begin
                  ptr_nxt    = sh_r;
                  st_nxt     = ST_P_ACK;
                  sda_oe_nxt = 1'b1;
               end
               if (st_r == ST_WDATA && bits_full && (scl_fall || stretch_r))
               begin
                  if (buf_in_ready)
                  begin
                     push        = 1'b1;
                     ptr_nxt     = ptr_inc;
                     st_nxt      = ST_D_ACK;
                     sda_oe_nxt  = 1'b1;
                     stretch_nxt = 1'b0;
                  end
                  else
                  begin
                     stretch_nxt = 1'b1;
                  end
               end
            end
            ST_A_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_nxt = ITS_BIT_ZERO;
                  if (rw_r)
                  begin
                     st_nxt     = ST_RDATA;
                     tx_nxt     = I_RD_DATA;
                     sda_oe_nxt = ~I_RD_DATA[7];
                  end
                  else
                  begin
                     st_nxt     = ST_PTR;
                     sda_oe_nxt = 1'b0;
                  end
               end
            end
            ST_P_ACK, ST_D_ACK:
            begin
               if (scl_fall)
               begin
                  st_nxt     = ST_WDATA;
                  cnt_nxt    = ITS_BIT_ZERO;
                  sda_oe_nxt = 1'b0;
               end
            end
            ST_RDATA:
            begin
               if (scl_rise)
               begin
                  cnt_nxt = cnt_r + 4'h1;
               end
               if (scl_fall)
               begin
                  if (bits_full)
                  begin
                     st_nxt     = ST_MACK;
                     sda_oe_nxt = 1'b0;
                  end
                  else
                  begin
                     tx_nxt     = {tx_r[6:0], 1'b0};
                     sda_oe_nxt = ~tx_r[6];
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  ptr_nxt = ptr_inc;
                  st_nxt  = sda_s_r ? ST_IGNORE : ST_MNEXT;
               end
            end
            ST_MNEXT:
            begin
               if (scl_fall)
               begin
                  st_nxt     = ST_RDATA;
                  cnt_nxt    = ITS_BIT_ZERO;
                  tx_nxt     = I_RD_DATA;
                  sda_oe_nxt = ~I_RD_DATA[7];
               end
            end
            default:
            begin
               st_nxt     = ST_IDLE;
               sda_oe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_B)
      begin
         st_r      <= ST_IDLE;
         cnt_r     <= ITS_BIT_ZERO;
         sh_r      <= ITS_PTR_RST;
         tx_r      <= ITS_PTR_RST;
         ptr_r     <= ITS_PTR_RST;
         sda_oe_r  <= 1'b0;
         stretch_r <= 1'b0;
         rw_r      <= 1'b0;
      end
      else
      begin
         st_r      <= st_nxt;
         cnt_r     <= cnt_nxt;
         sh_r      <= sh_nxt;
         tx_r      <= tx_nxt;
         ptr_r     <= ptr_nxt;
         sda_oe_r  <= sda_oe_nxt;
         stretch_r <= stretch_nxt;
         rw_r      <= rw_nxt;
      end
   end

   // pending-write flag; a new write wins over the phase clear
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RST_B)
      begin
         dirty_r <= 1'b0;
      end
      else
      begin
         dirty_r <= push | (dirty_r & ~I_PHASE_START);
      end
   end

   its_buf2 #(.DW(ITS_WORD_W)) u_buf
   (
      .i_clk       (I_CLK_SYS),
      .i_rst_b     (I_RST_B),
      .i_in_valid  (push),
      .o_in_ready  (buf_in_ready),
      .i_in_data   ({ptr_r, sh_r}),
      .o_out_valid (O_WR_VALID),
      .i_out_ready (I_WR_READY),
      .o_out_data  (buf_out_data)
   );

   // target only: lines are only ever pulled low, never driven high
   assign O_SDA_OUT  = 1'b0;
   assign O_SCL_OUT  = 1'b0;
   assign O_SDA_OE   = sda_oe_r;
   assign O_SCL_OE   = stretch_r;
   assign O_RD_ADDR  = ptr_r;
   assign O_WR_ADDR  = buf_out_data[15:8];
   assign O_WR_DATA  = buf_out_data[7:0];
   assign O_APPLY    = I_PHASE_START & dirty_r;
   assign O_OWN_ADDR = own_addr_r;

   chk_addr_nack: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_ADDR && byte_done && !addr_hit && !bus_start && !bus_stop)
      |=> (st_r == ST_IGNORE && !O_SDA_OE))
      else $error("mismatched address was acknowledged");

   chk_addr_ack: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_ADDR && byte_done && addr_hit && !bus_start && !bus_stop)
      |=> (st_r == ST_A_ACK && O_SDA_OE))
      else $error("matching address not acknowledged");

   chk_ptr_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_PTR && byte_done && !bus_start && !bus_stop)
      |=> (ptr_r == $past(sh_r) && O_SDA_OE))
      else $error("pointer byte not loaded or acknowledged");

   chk_write_step: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      push |=> (ptr_r == $past(ptr_r) + ITS_PTR_STEP && st_r == ST_D_ACK))
      else $error("pointer did not step after written byte");

   chk_write_ack: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      push |=> O_SDA_OE throughout (st_r == ST_D_ACK)[*1])
      else $error("data byte not acknowledged");

   chk_read_step: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_MACK && scl_rise && !bus_start && !bus_stop)
      |=> ptr_r == $past(ptr_r) + ITS_PTR_STEP)
      else $error("pointer did not step after read byte");

   chk_read_dir: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_A_ACK && scl_fall && rw_r && !bus_start && !bus_stop)
      |=> (st_r == ST_RDATA && O_SDA_OE == !$past(I_RD_DATA[7])))
      else $error("read direction did not start data output");

   chk_read_nack: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (st_r == ST_MACK && scl_rise && sda_s_r && !bus_start && !bus_stop)
      |=> (st_r == ST_IGNORE) ##1 !O_SDA_OE)
      else $error("read continued after host nack");

   chk_apply_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      push |=> dirty_r)
      else $error("pending write lost");

   chk_addr_catch: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      I_RST_B && !loaded_r
      |=> (O_OWN_ADDR == ($past(I_NVM_VALID) ? $past(I_NVM_ADDR) : ITS_DEF_ADDR)))
      else $error("bus address not taken from nonvolatile copy");

endmodule : its_target

`default_nettype wire
